// ---- hw/bpsp_pkg.sv ----
package bpsp_pkg;

    // Register indices as printed; the byte address is four times the index
    localparam logic [9:0]  IDX_BYTE_DATA      = 10'h008;
    localparam logic [9:0]  IDX_CTRL_DATA      = 10'h009;
    localparam logic [9:0]  IDX_BYTE_DIR       = 10'h088;
    localparam logic [9:0]  IDX_STATUS_CTRL    = 10'h089;
    localparam logic [9:0]  IDX_ANALOG_CFG     = 10'h09F;
    localparam logic [9:0]  IDX_XFER_IRQ       = 10'h0A0;
    localparam int          ADDR_W             = 12;

    // slave_port_status_ctrl fields
    localparam int          SC_INPUT_FULL      = 7;
    localparam int          SC_OUTPUT_FULL     = 6;
    localparam int          SC_OVERRUN         = 5;
    localparam int          SC_SLAVE_MODE      = 4;
    localparam int          SC_DIR_MSB         = 2;

    // slave_xfer_irq fields
    localparam int          IRQ_FLAG           = 0;
    localparam int          IRQ_ENABLE         = 1;

    // analog_pin_config fields
    localparam int          AC_SELECT_MSB      = 3;
    localparam int          AC_FORMAT          = 7;
    // Selections at or above this code leave all control pins digital
    localparam logic [3:0]  ANALOG_DIGITAL_MIN = 4'h6;

    // Control pin roles in slave mode
    localparam int          PIN_RD             = 0;
    localparam int          PIN_WR             = 1;
    localparam int          PIN_CS             = 2;

    // Reset values
    localparam logic [7:0]  RST_BYTE_DIR       = 8'hFF;
    localparam logic [2:0]  RST_CTRL_DIR       = 3'h7;
    localparam logic [7:0]  RST_ANALOG_CFG     = 8'h00;
    localparam logic [7:0]  RST_LATCH          = 8'h00;

    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

    typedef enum {
        BPSP_SEL_BYTE_DATA,
        BPSP_SEL_CTRL_DATA,
        BPSP_SEL_BYTE_DIR,
        BPSP_SEL_STATUS,
        BPSP_SEL_ANALOG,
        BPSP_SEL_IRQ,
        BPSP_SEL_NONE
    } bpsp_sel_t;

endpackage

// ---- hw/bpsp_top.sv ----
// Function
// - Each byte pin is GPIO or slave data bit, chosen by slave mode bit.
// - Three control pins, each with its own direction bit.
// - In slave mode, control pins are read, write and chip-select; their direction bits still apply.
// - Control pins selected analog read as zero in port data.
// - Direction bits drive control pin outputs even when analog.
// - After reset control pins are analog and read zero.
// - Control pin 0 is active-low read strobe in slave mode.
// - Write strobe low with chip selected latches byte pins into input.
// - Control pin 2 is active-low chip select; high ignores strobes.
// - Status bit 7 is read-only input-full flag.
// - Status bit 6 is read-only output-full flag.
// - Bit 5 set on write while input unread; cleared by writing zero.
// - Slave mode bit: one slave port, zero general I/O.
// - Status bit 3 is unimplemented and reads zero.
// - Status bits 2..0 set control pin direction; one is input.
// - Input-full sets shortly after write ends; in slave mode only data read clears it.
// - Read start clears output-full until firmware writes data again.
// - Outside slave mode full flags held clear; overrun kept.
// - Completed external transfer sets latched interrupt flag, gated by enable.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bpsp_top
    import bpsp_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        byte_pin_i,
    output logic [7:0]             byte_pin_o,
    output logic [7:0]             byte_pin_oe,
    input  wire logic [2:0]        ctrl_pin_i,
    output logic [2:0]             ctrl_pin_o,
    output logic [2:0]             ctrl_pin_oe,
    output logic                   slave_xfer_irq
);

    function automatic bpsp_sel_t decode(input logic [ADDR_W-1:0] addr);
        bpsp_sel_t sel;
        sel = BPSP_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[ADDR_W-1:2])
                IDX_BYTE_DATA:   sel = BPSP_SEL_BYTE_DATA;
                IDX_CTRL_DATA:   sel = BPSP_SEL_CTRL_DATA;
                IDX_BYTE_DIR:    sel = BPSP_SEL_BYTE_DIR;
                IDX_STATUS_CTRL: sel = BPSP_SEL_STATUS;
                IDX_ANALOG_CFG:  sel = BPSP_SEL_ANALOG;
                IDX_XFER_IRQ:    sel = BPSP_SEL_IRQ;
                default:         sel = BPSP_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // Registers
    logic [7:0]        out_latch_ff;
    logic [7:0]        in_latch_ff;
    logic [2:0]        ctrl_latch_ff;
    logic [7:0]        byte_dir_ff;
    logic [2:0]        ctrl_dir_ff;
    logic              slave_mode_select_ff;
    logic              input_full_flag_ff;
    logic              output_full_flag_ff;
    logic              input_overrun_flag_ff;
    logic [3:0]        analog_pin_select_ff;
    logic              analog_format_ff;
    logic              slave_xfer_irq_flag_ff;
    logic              slave_xfer_irq_enable_ff;

    // Bus slave state
    logic              aw_held_ff;
    logic              w_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0]       w_data_ff;
    logic [3:0]        w_strb_ff;
    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;

    // Pin synchronisers: three stages, accepted when stages two and three agree
    logic [10:0]       pin_s1_ff;
    logic [10:0]       pin_s2_ff;
    logic [10:0]       pin_s3_ff;
    logic [10:0]       pin_filt_ff;
    logic              wr_act_ff;
    logic              rd_act_ff;
    logic              wr_done_ff;
    logic              rd_done_ff;

    logic [7:0]        byte_pin_o_ff;
    logic [7:0]        byte_pin_oe_ff;
    logic [2:0]        ctrl_pin_o_ff;
    logic [2:0]        ctrl_pin_oe_ff;
    logic              slave_xfer_irq_ff;

    logic              wr_fire;
    logic              rd_fire;
    bpsp_sel_t         wr_sel;
    bpsp_sel_t         rd_sel;
    logic [7:0]        wbyte;
    logic              wr_lane;
    logic [7:0]        pins_byte;
    logic [2:0]        pins_ctrl;
    logic              ctrl_analog;
    logic              cs_n;
    logic              wr_n;
    logic              rd_n;
    logic              wr_act;
    logic              rd_act;
    logic              wr_start;
    logic              rd_start;
    logic              byte_data_read;
    logic [7:0]        status_rd;
    logic [7:0]        rd_value;

    assign wr_fire   = aw_held_ff && w_held_ff && !bvalid_ff;
    assign rd_fire   = s_axi_arvalid && arready_ff;
    assign wr_sel    = decode(aw_addr_ff);
    assign rd_sel    = decode(s_axi_araddr);
    assign wbyte     = w_data_ff[7:0];
    assign wr_lane   = wr_fire && w_strb_ff[0];
    assign pins_byte = pin_filt_ff[7:0];
    assign pins_ctrl = pin_filt_ff[10:8];

    assign ctrl_analog = analog_pin_select_ff < ANALOG_DIGITAL_MIN;

    // Strobes used only after synchronising and filtering
    assign cs_n   = pins_ctrl[PIN_CS];
    assign wr_n   = pins_ctrl[PIN_WR];
    assign rd_n   = pins_ctrl[PIN_RD];
    // Chip select high masks both strobes
    assign wr_act = slave_mode_select_ff && !cs_n && !wr_n;
    assign rd_act = slave_mode_select_ff && !cs_n && !rd_n;
    assign wr_start = wr_act && !wr_act_ff;
    assign rd_start = rd_act && !rd_act_ff;
    assign byte_data_read = rd_fire && rd_sel == BPSP_SEL_BYTE_DATA;

    assign status_rd = {input_full_flag_ff, output_full_flag_ff,
                        input_overrun_flag_ff, slave_mode_select_ff,
                        1'b0, ctrl_dir_ff};

    always_comb begin
        rd_value = 8'h00;
        case (rd_sel)
            // Slave mode returns the input latch, otherwise the pins
            BPSP_SEL_BYTE_DATA: rd_value = slave_mode_select_ff ?
                                           in_latch_ff : pins_byte;
            BPSP_SEL_CTRL_DATA: rd_value = ctrl_analog ? 8'h00 :
                                           {5'h00, pins_ctrl};
            BPSP_SEL_BYTE_DIR:  rd_value = byte_dir_ff;
            BPSP_SEL_STATUS:    rd_value = status_rd;
            BPSP_SEL_ANALOG:    rd_value = {analog_format_ff, 3'h0,
                                            analog_pin_select_ff};
            BPSP_SEL_IRQ:       rd_value = {6'h00, slave_xfer_irq_enable_ff,
                                            slave_xfer_irq_flag_ff};
            default:            rd_value = 8'h00;
        endcase
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awready_ff <= 1'b1;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            aw_held_ff <= 1'b1;
            awready_ff <= 1'b0;
            aw_addr_ff <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wready_ff <= 1'b1;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (s_axi_wvalid && wready_ff) begin
            w_held_ff <= 1'b1;
            wready_ff <= 1'b0;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
            wready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (wr_sel == BPSP_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else if (rd_fire) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {24'h00_0000, rd_value};
            rresp_ff   <= (rd_sel == BPSP_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    // Software-owned configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_dir_ff              <= RST_BYTE_DIR;
            ctrl_dir_ff              <= RST_CTRL_DIR;
            slave_mode_select_ff     <= 1'b0;
            analog_pin_select_ff     <= RST_ANALOG_CFG[AC_SELECT_MSB:0];
            analog_format_ff         <= RST_ANALOG_CFG[AC_FORMAT];
            slave_xfer_irq_enable_ff <= 1'b0;
            out_latch_ff             <= RST_LATCH;
            ctrl_latch_ff            <= RST_LATCH[2:0];
        end else if (wr_lane) begin
            case (wr_sel)
                BPSP_SEL_BYTE_DATA: out_latch_ff <= wbyte;
                BPSP_SEL_CTRL_DATA: ctrl_latch_ff <= wbyte[2:0];
                BPSP_SEL_BYTE_DIR:  byte_dir_ff <= wbyte;
                BPSP_SEL_STATUS: begin
                    slave_mode_select_ff <= wbyte[SC_SLAVE_MODE];
                    ctrl_dir_ff <= wbyte[SC_DIR_MSB:0];
                end
                BPSP_SEL_ANALOG: begin
                    analog_pin_select_ff <= wbyte[AC_SELECT_MSB:0];
                    analog_format_ff     <= wbyte[AC_FORMAT];
                end
                BPSP_SEL_IRQ: slave_xfer_irq_enable_ff <= wbyte[IRQ_ENABLE];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // All stages start at the idle level so no false strobe follows reset
            pin_s1_ff   <= 11'h7FF;
            pin_s2_ff   <= 11'h7FF;
            pin_s3_ff   <= 11'h7FF;
            pin_filt_ff <= 11'h7FF;
        end else begin
            pin_s1_ff <= {ctrl_pin_i, byte_pin_i};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            for (int i = 0; i < 11; i++) begin
                if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                    pin_filt_ff[i] <= pin_s3_ff[i];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_act_ff  <= 1'b0;
            rd_act_ff  <= 1'b0;
            wr_done_ff <= 1'b0;
            rd_done_ff <= 1'b0;
        end else begin
            wr_act_ff  <= wr_act;
            rd_act_ff  <= rd_act;
            // One cycle pause stands in for the wait to the next phase
            wr_done_ff <= wr_act_ff && !wr_act;
            rd_done_ff <= rd_act_ff && !rd_act;
        end
    end

    // Bytes follow the pins for the whole strobe; the last one wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_latch_ff <= RST_LATCH;
        end else if (wr_act) begin
            in_latch_ff <= pins_byte;
        end
    end

    // Set beats a same-cycle clear by the processor read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_full_flag_ff <= 1'b0;
        end else if (!slave_mode_select_ff) begin
            input_full_flag_ff <= 1'b0;
        end else if (wr_done_ff) begin
            input_full_flag_ff <= 1'b1;
        end else if (byte_data_read) begin
            input_full_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_full_flag_ff <= 1'b0;
        end else if (!slave_mode_select_ff) begin
            output_full_flag_ff <= 1'b0;
        end else if (wr_lane && wr_sel == BPSP_SEL_BYTE_DATA) begin
            output_full_flag_ff <= 1'b1;
        end else if (rd_start) begin
            output_full_flag_ff <= 1'b0;
        end
    end

    // Overrun is kept across mode changes; only writing zero clears it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_overrun_flag_ff <= 1'b0;
        end else if (wr_start && input_full_flag_ff) begin
            input_overrun_flag_ff <= 1'b1;
        end else if (wr_lane && wr_sel == BPSP_SEL_STATUS
                     && !wbyte[SC_OVERRUN]) begin
            input_overrun_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slave_xfer_irq_flag_ff <= 1'b0;
        end else if (wr_done_ff || rd_done_ff) begin
            slave_xfer_irq_flag_ff <= 1'b1;
        end else if (wr_lane && wr_sel == BPSP_SEL_IRQ
                     && !wbyte[IRQ_FLAG]) begin
            slave_xfer_irq_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slave_xfer_irq_ff <= 1'b0;
        end else begin
            slave_xfer_irq_ff <= slave_xfer_irq_flag_ff
                                 && slave_xfer_irq_enable_ff;
        end
    end

    // Pin drivers; direction register ignored in slave mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_pin_o_ff  <= RST_LATCH;
            byte_pin_oe_ff <= 8'h00;
        end else begin
            byte_pin_o_ff <= out_latch_ff;
            if (slave_mode_select_ff) begin
                byte_pin_oe_ff <= {8{rd_act}};
            end else begin
                byte_pin_oe_ff <= ~byte_dir_ff;
            end
        end
    end

    // Analog selection does not gate the drivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_pin_o_ff  <= RST_LATCH[2:0];
            ctrl_pin_oe_ff <= 3'h0;
        end else begin
            ctrl_pin_o_ff  <= ctrl_latch_ff;
            ctrl_pin_oe_ff <= ~ctrl_dir_ff;
        end
    end

    assign s_axi_awready  = awready_ff;
    assign s_axi_wready   = wready_ff;
    assign s_axi_bvalid   = bvalid_ff;
    assign s_axi_bresp    = bresp_ff;
    assign s_axi_arready  = arready_ff;
    assign s_axi_rvalid   = rvalid_ff;
    assign s_axi_rdata    = rdata_ff;
    assign s_axi_rresp    = rresp_ff;
    assign byte_pin_o     = byte_pin_o_ff;
    assign byte_pin_oe    = byte_pin_oe_ff;
    assign ctrl_pin_o     = ctrl_pin_o_ff;
    assign ctrl_pin_oe    = ctrl_pin_oe_ff;
    assign slave_xfer_irq = slave_xfer_irq_ff;

endmodule
`default_nettype wire

// ---- testbench/bpsp_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module bpsp_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  byte_pin_oe,
    input wire logic [2:0]  ctrl_pin_oe
);
    logic [11:0] rd_addr_ff;
    // Returned word is judged by the register it came from
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_ff <= s_axi_araddr;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer not one cycle after execution");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    rd_busy_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after take");
    gap_bit_a: assert property (
        s_axi_rvalid && rd_addr_ff == 12'h224 |-> !s_axi_rdata[3])
        else $error("status bit 3 not zero");
    ctrl_read_a: assert property (
        s_axi_rvalid && rd_addr_ff == 12'h024 |-> s_axi_rdata[7:3] == '0)
        else $error("control data upper bits not zero");
    dir_oe_a: assert property (
        $changed(ctrl_pin_oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("control enables moved without a write");
    byte_oe_a: assert property (
        $changed(byte_pin_oe) && !s_axi_bvalid && !$past(s_axi_bvalid)
        |-> byte_pin_oe == 8'hFF || byte_pin_oe == 8'h00)
        else $error("byte enables moved to a partial value");
endmodule
bind bpsp_top bpsp_assertions u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .byte_pin_oe(byte_pin_oe), .ctrl_pin_oe(ctrl_pin_oe)
);
`default_nettype wire

// ---- testbench/bpsp_ext_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module bpsp_ext_master (
    input  wire logic       clk,
    input  wire logic [7:0] bus,
    output logic      [7:0] byte_drv,
    output logic      [2:0] ctrl_drv
);
    initial begin
        byte_drv = 8'h00;
        ctrl_drv = 3'h7;
    end
    task automatic hold(input logic [7:0] d);
        @(posedge clk);
        byte_drv <= d;
    endtask
    // One strobe; sel_n is the chip select level, data held past release
    task automatic xfer(input logic rd, input logic sel_n,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        ctrl_drv <= {sel_n, rd, !rd};
        byte_drv <= rd ? ~byte_drv : d;
        repeat (8) @(posedge clk);
        q = bus;
        ctrl_drv <= 3'h7;
        repeat (8) @(posedge clk);
        // Released lines must not keep the last value
        byte_drv <= ~bus;
    endtask
endmodule
`default_nettype wire

// ---- testbench/bpsp_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    error_cnt++; $display("unexpected at %0t: got %h expected %h", \
    $time, g, e); end end
module bpsp_top_bench import bpsp_pkg::*;;
    localparam logic [11:0] A_DATA = {IDX_BYTE_DATA, 2'h0};
    localparam logic [11:0] A_CTRL = {IDX_CTRL_DATA, 2'h0};
    localparam logic [11:0] A_DIR  = {IDX_BYTE_DIR, 2'h0};
    localparam logic [11:0] A_STAT = {IDX_STATUS_CTRL, 2'h0};
    localparam logic [11:0] A_ANA  = {IDX_ANALOG_CFG, 2'h0};
    localparam logic [11:0] A_IRQ  = {IDX_XFER_IRQ, 2'h0};
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, slave_xfer_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  byte_pin_o, byte_pin_oe, pd;
    logic [2:0]  ctrl_pin_o, ctrl_pin_oe;
    wire  [7:0]  ext_byte, byte_bus;
    wire  [2:0]  ext_ctrl, ctrl_bus;
    int          error_cnt = 0, compares = 0;
    assign byte_bus = (byte_pin_oe & byte_pin_o) | (~byte_pin_oe & ext_byte);
    assign ctrl_bus = (ctrl_pin_oe & ctrl_pin_o) | (~ctrl_pin_oe & ext_ctrl);
    always #2 aclk = ~aclk;
    bpsp_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .byte_pin_i(byte_bus),
        .byte_pin_o(byte_pin_o), .byte_pin_oe(byte_pin_oe),
        .ctrl_pin_i(ctrl_bus), .ctrl_pin_o(ctrl_pin_o),
        .ctrl_pin_oe(ctrl_pin_oe), .slave_xfer_irq(slave_xfer_irq));
    bpsp_ext_master ext (.clk(aclk), .bus(byte_bus),
        .byte_drv(ext_byte), .ctrl_drv(ext_ctrl));
    task automatic stop_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= {24'h00_0000, d};
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid  <= 1'h1;
            s_axi_bready  <= 1'h1;
        end else begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready  <= 1'h1;
        end
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'h1 && n < 50);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        if (n == 50) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        acc(1'h1, a, d);
        `CHK(r, RESP_OKAY)
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h00);
        `CHK(q, {24'h00_0000, e})
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rd(A_DIR, RST_BYTE_DIR);
        rd(A_STAT, 8'h07);
        rd(A_ANA, RST_ANALOG_CFG);
        rd(A_CTRL, 8'h00);
        acc(1'h0, 12'h100, 8'h00);
        `CHK(r, RESP_SLVERR)
        ext.hold(8'h3C);
        wr(A_DIR, 8'h0F);
        wr(A_DATA, 8'hA5);
        // Pin filter needs four edges before the read samples the new level
        repeat (3) @(posedge aclk);
        `CHK(byte_pin_oe, 8'hF0)
        `CHK(byte_pin_o, 8'hA5)
        rd(A_DATA, 8'hAC);
        wr(A_CTRL, 8'h05);
        wr(A_STAT, 8'h02);
        repeat (2) @(posedge aclk);
        `CHK(ctrl_pin_oe, 3'h5)
        `CHK(ctrl_pin_o, 3'h5)
        wr(A_STAT, 8'h07);
        wr(A_ANA, 8'h06);
        rd(A_CTRL, 8'h07);
        wr(A_STAT, 8'h17);
        wr(A_DATA, 8'h5A);
        rd(A_STAT, 8'h57);
        ext.xfer(1'h1, 1'h0, 8'h00, pd);
        `CHK(pd, 8'h5A)
        `CHK(byte_pin_oe, 8'h00)
        rd(A_STAT, 8'h17);
        ext.xfer(1'h0, 1'h0, 8'h3C, pd);
        rd(A_STAT, 8'h97);
        rd(A_IRQ, 8'h01);
        wr(A_IRQ, 8'h03);
        repeat (2) @(posedge aclk);
        `CHK(slave_xfer_irq, 1'h1)
        wr(A_IRQ, 8'h02);
        repeat (2) @(posedge aclk);
        `CHK(slave_xfer_irq, 1'h0)
        ext.xfer(1'h0, 1'h1, 8'h11, pd);
        rd(A_STAT, 8'h97);
        ext.xfer(1'h0, 1'h0, 8'h77, pd);
        rd(A_STAT, 8'hB7);
        rd(A_DATA, 8'h77);
        rd(A_STAT, 8'h37);
        ext.xfer(1'h0, 1'h0, 8'h42, pd);
        wr(A_STAT, 8'h27);
        rd(A_STAT, 8'h27);
        wr(A_STAT, 8'h07);
        rd(A_STAT, 8'h07);
        stop_test();
    end
endmodule
`default_nettype wire
